// ### design/scan_reg_pkg.sv
// package: widths, reset values and mode codes for the scannable register
package scan_reg_pkg;
  localparam int unsigned DATA_WIDTH = 8;                 // register width
  localparam logic [DATA_WIDTH-1:0] REG_RESET = 8'h00;    // value after clear
  localparam int unsigned SCAN_IN_POS = 0;                // serial input enters here
  // operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_CLEAR = 4'h1,
    MODE_SHIFT = 4'h2,
    MODE_HOLD  = 4'h4,
    MODE_LOAD  = 4'h8
  } mode_t;
endpackage

// ### design/scan_bit_cell.sv
// one storage bit with load/hold/shift selection
`timescale 1ns/1ps
`default_nettype none
module scan_bit_cell (
  input wire logic sys_clk,     // system clock
  input wire logic async_clear, // active-high clear
  input wire logic shift_select, // shift overrides hold/load
  input wire logic hold_load_select, // 1 hold, 0 load
  input wire logic par_bit,     // parallel data bit
  input wire logic shift_bit,   // bit from lower neighbour
  output logic bit_reg          // stored bit
);
  // clear is async and wins over all controls
  always_ff @(posedge sys_clk or posedge async_clear)
  begin
    if (async_clear)
      bit_reg <= 1'b0;
    else if (shift_select)
      bit_reg <= shift_bit;
    else if (!hold_load_select)
      bit_reg <= par_bit;
  end
endmodule
`default_nettype wire

// ### design/scannable_shift_register_8bit.sv
// eight-bit scannable register: parallel load, hold, serial shift, async clear
// Functional notes
// - eight bits in, eight bits out
// - shift select overrides hold/load select
// - shift takes one serial bit per edge
// - select low, load low: parallel capture
// - select low, load high: hold contents
// - all loads and shifts on rising clock edge
// - clear high zeroes all bits immediately
`timescale 1ns/1ps
`default_nettype none
module scannable_shift_register_8bit
  import scan_reg_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_WIDTH // register width
) (
  input wire logic sys_clk,              // system clock, 200 MHz
  input wire logic rst_n,                // active-low reset, joins the master clear
  input wire logic async_clear,          // active-high master clear
  input wire logic shift_select,         // 1 = shift
  input wire logic hold_load_select,     // 1 = hold, 0 = load
  input wire logic serial_in,            // scan data in
  input wire logic [WIDTH-1:0] parallel_in, // parallel data
  output logic [WIDTH-1:0] reg_out,      // stored bits
  output logic scan_out                  // top bit, for chaining
);
  // width must allow a shift chain; one bit has no neighbour to shift from
  if (WIDTH < 2)
  begin : g_bad_width
    $error("WIDTH must be at least 2");
  end

  // the chain below is wired for serial entry at bit 0 only
  if (SCAN_IN_POS != 0)
  begin : g_bad_entry
    $error("serial entry must be bit 0");
  end

  // clear value at this width; the package gives it for eight bits
  localparam logic [WIDTH-1:0] CLEAR_VALUE = WIDTH'(REG_RESET);

  // either clear source empties the register at once, no clock needed
  // a gated reset is a glitch hazard in silicon; both inputs must be clean pins
  logic clear_any; // master clear or active-low reset
  assign clear_any = async_clear | ~rst_n;

  logic [WIDTH-1:0] shift_src; // what each cell takes in shift mode

  // chain: serial into bit 0, each bit moves up one place
  // pure wiring, so a shift costs no more than a load
  assign shift_src = {reg_out[WIDTH-2:0], serial_in};

  // one cell per bit; cells are flops so outputs come from flops
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_cell
    scan_bit_cell u_cell (
      .sys_clk(sys_clk),                // all cells on one edge
      .async_clear(clear_any),
      .shift_select(shift_select),
      .hold_load_select(hold_load_select),
      .par_bit(parallel_in[i]),
      .shift_bit(shift_src[i]),
      .bit_reg(reg_out[i])
    );
  end

  // scan output is the top bit; a copy flop keeps it a register output
  // the copy follows the cells' mode table, so it never lags bit 7
  always_ff @(posedge sys_clk or posedge clear_any)
  begin
    if (clear_any)
      scan_out <= 1'b0;
    else if (shift_select)
      scan_out <= reg_out[WIDTH-2];
    else if (!hold_load_select)
      scan_out <= parallel_in[WIDTH-1];
    // hold leaves the copy, as the cells keep bit 7
  end

  // current mode, for the checks below
  mode_t mode; // decoded from clear and the two selects
  always_comb
  begin
    if (clear_any)
      mode = MODE_CLEAR; // clear beats every select
    else if (shift_select)
      mode = MODE_SHIFT;
    else if (hold_load_select)
      mode = MODE_HOLD; // hold wanted
    else
      mode = MODE_LOAD; // both selects low
  end

  // checks below sample at the rising edge; a clear disables all but the two clear checks
  // because it may land anywhere in the cycle

  // one edge with a shift requested
  sequence s_shift_cmd;
    !clear_any && shift_select;
  endsequence

  // one edge with a parallel load requested
  sequence s_load_cmd;
    mode == MODE_LOAD;
  endsequence

  // one edge with a hold requested
  sequence s_hold_cmd;
    mode == MODE_HOLD;
  endsequence

  // two shifts back to back
  sequence s_two_shifts;
    s_shift_cmd ##1 s_shift_cmd;
  endsequence

  // a load, then a hold on the next edge
  sequence s_load_then_hold;
    s_load_cmd ##1 s_hold_cmd;
  endsequence

  // shift: every bit moves up one, serial bit enters at the bottom
  property p_shift;
    @(posedge sys_clk) disable iff (clear_any)
      s_shift_cmd |=> reg_out == {$past(reg_out[WIDTH-2:0]), $past(serial_in)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift result wrong");

  // two shifts in a row keep both serial bits, in order
  // catches a chain that drops or repeats a bit
  property p_shift_two;
    @(posedge sys_clk) disable iff (clear_any)
      s_two_shifts |=> reg_out[1:0] == {$past(serial_in, 2), $past(serial_in)};
  endproperty
  a_shift_two: assert property (p_shift_two) else $error("serial bits out of order");

  // shift wins while hold is selected
  property p_shift_over;
    @(posedge sys_clk) disable iff (clear_any)
      (shift_select && hold_load_select) |=> reg_out[SCAN_IN_POS] == $past(serial_in);
  endproperty
  a_shift_over: assert property (p_shift_over) else $error("shift not overriding hold");

  // shift wins while load is selected: parallel data must not land
  property p_shift_no_load;
    @(posedge sys_clk) disable iff (clear_any)
      (shift_select && !hold_load_select) |=> reg_out[WIDTH-1:1] == $past(reg_out[WIDTH-2:0]);
  endproperty
  a_shift_no_load: assert property (p_shift_no_load) else $error("load beat shift");

  // load: all bits from the parallel inputs
  property p_load;
    @(posedge sys_clk) disable iff (clear_any)
      s_load_cmd |=> reg_out == $past(parallel_in);
  endproperty
  a_load: assert property (p_load) else $error("load failed");

  // load also refreshes the scan copy
  property p_load_top;
    @(posedge sys_clk) disable iff (clear_any)
      s_load_cmd |=> scan_out == $past(parallel_in[WIDTH-1]);
  endproperty
  a_load_top: assert property (p_load_top) else $error("scan copy missed load");

  // hold: contents unchanged whatever the parallel inputs do
  property p_hold;
    @(posedge sys_clk) disable iff (clear_any)
      s_hold_cmd |=> $stable(reg_out);
  endproperty
  a_hold: assert property (p_hold) else $error("hold changed data");

  // hold keeps the scan copy too
  property p_hold_top;
    @(posedge sys_clk) disable iff (clear_any)
      s_hold_cmd |=> $stable(scan_out);
  endproperty
  a_hold_top: assert property (p_hold_top) else $error("scan copy moved in hold");

  // master clear: all zero at every edge it covers
  // not disabled by the clear, since the clear is what it watches
  property p_clear;
    @(posedge sys_clk)
      async_clear |-> (reg_out == CLEAR_VALUE && !scan_out);
  endproperty
  a_clear: assert property (p_clear) else $error("clear not zero");

  // active-low reset clears just as the master clear does
  property p_rst_clear;
    @(posedge sys_clk)
      !rst_n |-> (reg_out == CLEAR_VALUE && !scan_out);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset not zero");

  // scan output mirrors bit 7 once a cycle has passed
  // the copy flop and the top cell must never drift apart
  property p_scan_out;
    @(posedge sys_clk) disable iff (clear_any)
      ##1 1'b1 |-> scan_out == reg_out[WIDTH-1];
  endproperty
  a_scan_out: assert property (p_scan_out) else $error("scan out mismatch");

  // on a shift the scan output takes the old bit below the top
  property p_shift_top;
    @(posedge sys_clk) disable iff (clear_any)
      s_shift_cmd |=> scan_out == $past(reg_out[WIDTH-2]);
  endproperty
  a_shift_top: assert property (p_shift_top) else $error("scan out missed shift");

  // a loaded word survives a following hold, all bits intact
  // a narrow or crossed data path shows up here
  property p_width;
    @(posedge sys_clk) disable iff (clear_any)
      s_load_then_hold |=> reg_out == $past(parallel_in, 2);
  endproperty
  a_width: assert property (p_width) else $error("parallel word lost");

  // contents change only after an edge that loads or shifts
  // a change in hold would mean a level-sensitive path
  property p_edge;
    @(posedge sys_clk) disable iff (clear_any)
      $changed(reg_out) |-> $past(mode) != MODE_HOLD;
  endproperty
  a_edge: assert property (p_edge) else $error("change without command");
endmodule
`default_nettype wire

// ### sim/scan_ctrl_model.sv
// stand-in for the surrounding logic that presents controls and data
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
  input wire logic sys_clk, // system clock
  input wire logic [10:0] req, // shift, hold, serial, data
  output logic shift_select, // to register
  output logic hold_load_select, // to register
  output logic serial_in, // to register
  output logic [7:0] parallel_in // to register
);
  initial {shift_select, hold_load_select, serial_in, parallel_in} = '0;
  // levels move just after an edge, so they are settled before the next
  always @(posedge sys_clk) {shift_select, hold_load_select, serial_in, parallel_in} <= req;
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the eight-bit scannable register
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scan_reg_pkg::*;
  logic sys_clk = 1'b0; // 200 MHz
  logic async_clear = 1'b0; // master clear, raised just after time zero so the flops see an edge
  logic rst_n = 1'b1; // active-low reset, lowered with the clear
  logic [10:0] req = '0; // request to the control model
  logic shift_select, hold_load_select, serial_in, scan_out; // design pins
  logic [7:0] parallel_in, reg_out, exp_q = REG_RESET; // data and expected value
  int num_errors = 0, num_checks = 0; // counters
  scan_ctrl_model scan_ctrl_model_i (.sys_clk(sys_clk), .req(req), .shift_select(shift_select),
    .hold_load_select(hold_load_select), .serial_in(serial_in), .parallel_in(parallel_in));
  scannable_shift_register_8bit scannable_shift_register_8bit_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .async_clear(async_clear), .shift_select(shift_select), .hold_load_select(hold_load_select),
    .serial_in(serial_in), .parallel_in(parallel_in), .reg_out(reg_out), .scan_out(scan_out));
  initial forever #2.5 sys_clk = ~sys_clk;
  // next contents from the mode table; shift wins over hold/load
  function automatic logic [7:0] next_q(logic [7:0] q, logic sh, logic hl, logic si, logic [7:0] d);
    if (sh) return {q[6:0], si};
    return hl ? q : d;
  endfunction
  // reference copy, sampled before the model's updates land; either clear acts at once
  always @(posedge sys_clk or posedge async_clear or negedge rst_n)
    if (async_clear || !rst_n) exp_q = REG_RESET;
    else exp_q = next_q(exp_q, shift_select, hold_load_select, serial_in, parallel_in);
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // compare mid-cycle, where outputs have settled
  always @(negedge sys_clk)
  begin
    check("reg_out", reg_out, exp_q);
    check("scan_out", {7'h0, scan_out}, {7'h0, exp_q[7]});
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: the tests need well under 500 cycles
  initial
  begin
    #5000;
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(22));
    #1 async_clear = 1'b1;
    rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 async_clear = 1'b0;
    rst_n = 1'b1;
    repeat (300) @(posedge sys_clk) req <= 11'($urandom);
    $display("random modes done");
    // eight shifts with load selected and data waiting, then hold, then loads back to back
    for (int i = 0; i < 8; i++) @(posedge sys_clk) req <= {2'b10, i[0], 8'hff};
    repeat (4) @(posedge sys_clk) req <= {3'b011, 8'h5a};
    @(posedge sys_clk) req <= {3'b001, 8'ha5};
    @(posedge sys_clk) req <= {3'b000, 8'h3c};
    repeat (2) @(posedge sys_clk);
    $display("corner sequence done");
    // clear in mid-cycle must act without an edge, and hold off shifting
    #1 async_clear = 1'b1;
    #1 check("cleared", reg_out, REG_RESET);
    repeat (3) @(posedge sys_clk) req <= {3'b101, 8'hff};
    #1 check("held clear", reg_out, REG_RESET);
    async_clear = 1'b0;
    repeat (3) @(posedge sys_clk);
    $display("clear test done");
    // the active-low reset empties the shifted-in ones just as the clear does
    #1 rst_n = 1'b0;
    #1 check("reset cleared", reg_out, REG_RESET);
    @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
